// *** shared/ccd_pkg.sv ***
// constants and types shared by the clock channel divider
package ccd_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W         = 9;
   localparam int          DATA_W         = 8;
   localparam logic [8:0]  ADDR_PERIOD    = 9'h190;
   localparam logic [8:0]  ADDR_CONTROL   = 9'h191;
   localparam logic [8:0]  ADDR_STATUS    = 9'h1f0;

   localparam logic [7:0]  PERIOD_RESET   = 8'h00;
   localparam logic [7:0]  CONTROL_RESET  = 8'h80;
   localparam logic [7:0]  READ_NONE      = 8'h00;

   // ----------------------------------------------------------------
   // field layouts
   // ----------------------------------------------------------------
   localparam int          CNT_W          = 4;
   localparam int          RUN_W          = 5;

   typedef struct packed {
      logic [3:0] low_cycles;
      logic [3:0] high_cycles;
   } ccd_period_type;

   typedef struct packed {
      logic       bypass;
      logic       nosync;
      logic       force_high;
      logic       start_high;
      logic [3:0] phase;
   } ccd_control_type;

   // status word: bit 0 level, 1 running, 2 sync held, 3 bypass, 4 forced, 5 sync seen
   typedef struct packed {
      logic [1:0] spare;
      logic       sync_seen;
      logic       forced;
      logic       bypassed;
      logic       sync_held;
      logic       running;
      logic       level;
   } ccd_status_type;

   localparam int          STAT_SEEN_BIT  = 5;

   typedef enum logic [2:0] {
      ST_BYPASS,
      ST_FORCE,
      ST_HOLD,
      ST_RUN
   } ccd_state_type;

endpackage

// *** logic/ccd_counter.sv ***
// down counter that times each output level
`timescale 1ns/1ps
module ccd_counter #(
   parameter int W = 5
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_load_val,
   input  wire logic         i_hold,
   output logic              o_zero
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   // ----------------------------------------------------------------
   // next count
   // ----------------------------------------------------------------
   always_comb begin
      cnt_next = cnt_reg;
      if (i_hold) begin
         cnt_next = '0;
      end else if (i_load) begin
         cnt_next = i_load_val;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - W'(1);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign o_zero = (cnt_reg == '0);

endmodule // ccd_counter

// *** logic/ccd_regs.sv ***
// configuration and status registers of the divider
`timescale 1ns/1ps
module ccd_regs (
   input  wire logic                     i_core_clk,
   input  wire logic                     i_resetn,
   input  wire logic [ccd_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [ccd_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                     i_wr,
   input  wire logic                     i_rd,
   input  wire logic                     i_sync_event,
   input  wire ccd_pkg::ccd_status_type  i_status,
   output ccd_pkg::ccd_period_type       o_period,
   output ccd_pkg::ccd_control_type      o_control,
   output logic [ccd_pkg::DATA_W-1:0]    o_rdata
);

   ccd_pkg::ccd_period_type  period_reg,  period_next;
   ccd_pkg::ccd_control_type control_reg, control_next;
   logic                     seen_reg,    seen_next;
   logic [ccd_pkg::DATA_W-1:0] rdata_reg, rdata_next;
   ccd_pkg::ccd_status_type  stat;

   // ----------------------------------------------------------------
   // write, sticky flag and read decode
   // ----------------------------------------------------------------
   always_comb begin
      period_next  = period_reg;
      control_next = control_reg;
      seen_next    = seen_reg;
      rdata_next   = ccd_pkg::READ_NONE;
      stat         = i_status;
      stat.sync_seen = seen_reg;
      if (i_wr) begin
         if (i_addr == ccd_pkg::ADDR_PERIOD) begin
            period_next = ccd_pkg::ccd_period_type'(i_wdata);
         end else if (i_addr == ccd_pkg::ADDR_CONTROL) begin
            control_next = ccd_pkg::ccd_control_type'(i_wdata);
         end else if (i_addr == ccd_pkg::ADDR_STATUS) begin
            if (i_wdata[ccd_pkg::STAT_SEEN_BIT]) begin
               seen_next = 1'b0;
            end
         end
      end
      // set beats clear
      if (i_sync_event) begin
         seen_next = 1'b1;
      end
      if (i_rd) begin
         if (i_addr == ccd_pkg::ADDR_PERIOD) begin
            rdata_next = period_reg;
         end else if (i_addr == ccd_pkg::ADDR_CONTROL) begin
            rdata_next = control_reg;
         end else if (i_addr == ccd_pkg::ADDR_STATUS) begin
            rdata_next = stat;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         period_reg  <= ccd_pkg::PERIOD_RESET;
         control_reg <= ccd_pkg::CONTROL_RESET;
         seen_reg    <= 1'b0;
         rdata_reg   <= ccd_pkg::READ_NONE;
      end else begin
         period_reg  <= period_next;
         control_reg <= control_next;
         seen_reg    <= seen_next;
         rdata_reg   <= rdata_next;
      end
   end

   assign o_period  = period_reg;
   assign o_control = control_reg;
   assign o_rdata   = rdata_reg;

endmodule // ccd_regs

// *** logic/ccd_top.sv ***
// clock channel divider: programmable high/low divider with sync, bypass and force
//
// Operation
// - low field [7:4] of period register gives low cycles minus one.
// - high field [3:0] of period register gives high cycles minus one.
// - bypass bit 7 powers divider down, input clock passes; set after reset.
// - bit 6 clear obeys chip sync; bit 6 set ignores it entirely.
// - bit 5 forces output high, only when bit 6 also set.
// - bit 4 picks start level after starting: clear low, set high.
// - phase offset field [3:0] of control register sets start phase, resets zero.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module ccd_top (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_resetn,
   input  wire logic [ccd_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [ccd_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                       i_wr,
   input  wire logic                       i_rd,
   input  wire logic                       i_sync_n,
   output logic [ccd_pkg::DATA_W-1:0]      o_rdata,
   output logic                            o_div_out,
   output logic                            o_div_bypass,
   output logic                            o_div_running
);

   // ----------------------------------------------------------------
   // sync pin synchroniser
   // ----------------------------------------------------------------
   logic sync_meta_reg, sync_meta_next;
   logic sync_safe_reg, sync_safe_next;
   logic sync_last_reg, sync_last_next;

   always_comb begin
      sync_meta_next = ~i_sync_n;
      sync_safe_next = sync_meta_reg;
      sync_last_next = sync_safe_reg;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         sync_meta_reg <= 1'b0;
         sync_safe_reg <= 1'b0;
         sync_last_reg <= 1'b0;
      end else begin
         sync_meta_reg <= sync_meta_next;
         sync_safe_reg <= sync_safe_next;
         sync_last_reg <= sync_last_next;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   ccd_pkg::ccd_period_type  period;
   ccd_pkg::ccd_control_type control;
   ccd_pkg::ccd_status_type  status;
   logic                     sync_obeyed;
   logic                     sync_event;

   assign sync_obeyed = sync_safe_reg & ~control.nosync;
   assign sync_event  = sync_obeyed & ~sync_last_reg;

   ccd_regs u_regs (
      .i_core_clk   (i_core_clk),
      .i_resetn     (i_resetn),
      .i_addr       (i_addr),
      .i_wdata      (i_wdata),
      .i_wr         (i_wr),
      .i_rd         (i_rd),
      .i_sync_event (sync_event),
      .i_status     (status),
      .o_period     (period),
      .o_control    (control),
      .o_rdata      (o_rdata)
   );

   // ----------------------------------------------------------------
   // level timer
   // ----------------------------------------------------------------
   function automatic logic [ccd_pkg::RUN_W-1:0] level_len(
      input ccd_pkg::ccd_period_type p,
      input logic                    high
   );
      level_len = high ? {1'b0, p.high_cycles} : {1'b0, p.low_cycles};
   endfunction

   ccd_pkg::ccd_state_type       state_reg, state_next;
   logic                         level_reg, level_next;
   logic                         cnt_load;
   logic [ccd_pkg::RUN_W-1:0]    cnt_val;
   logic                         cnt_hold;
   logic                         cnt_zero;
   logic                         bypass_reg,  bypass_next;
   logic                         running_reg, running_next;

   ccd_counter #(
      .W (ccd_pkg::RUN_W)
   ) u_counter (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_load     (cnt_load),
      .i_load_val (cnt_val),
      .i_hold     (cnt_hold),
      .o_zero     (cnt_zero)
   );

   // ----------------------------------------------------------------
   // divider state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      level_next = level_reg;
      cnt_load   = 1'b0;
      cnt_val    = '0;
      cnt_hold   = 1'b0;
      if (control.bypass) begin
         // divider powered down, input clock routed by o_div_bypass
         state_next = ccd_pkg::ST_BYPASS;
         level_next = 1'b0;
         cnt_hold   = 1'b1;
      end else if (control.nosync && control.force_high) begin
         state_next = ccd_pkg::ST_FORCE;
         level_next = 1'b1;
         cnt_hold   = 1'b1;
      end else if (sync_obeyed) begin
         // held in sync: park at the start level
         state_next = ccd_pkg::ST_HOLD;
         level_next = control.start_high;
         cnt_hold   = 1'b1;
      end else begin
         case (state_reg)
            ccd_pkg::ST_RUN: begin
               if (cnt_zero) begin
                  level_next = ~level_reg;
                  cnt_load   = 1'b1;
                  cnt_val    = level_len(period, ~level_reg);
               end
            end
            default: begin
               // restart: start level, first edge after phase plus one level time
               state_next = ccd_pkg::ST_RUN;
               level_next = control.start_high;
               cnt_load   = 1'b1;
               cnt_val    = ccd_pkg::RUN_W'({1'b0, control.phase})
                          + level_len(period, control.start_high);
            end
         endcase
      end
      // pin flags follow the state flop, registered from its next value
      bypass_next  = (state_next == ccd_pkg::ST_BYPASS);
      running_next = (state_next == ccd_pkg::ST_RUN);
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         state_reg   <= ccd_pkg::ST_BYPASS;
         level_reg   <= 1'b0;
         bypass_reg  <= 1'b1;
         running_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         level_reg   <= level_next;
         bypass_reg  <= bypass_next;
         running_reg <= running_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs and status
   // ----------------------------------------------------------------
   assign o_div_out     = level_reg;
   assign o_div_bypass  = bypass_reg;
   assign o_div_running = running_reg;

   always_comb begin
      status           = '0;
      status.level     = level_reg;
      status.running   = (state_reg == ccd_pkg::ST_RUN);
      status.sync_held = (state_reg == ccd_pkg::ST_HOLD);
      status.bypassed  = (state_reg == ccd_pkg::ST_BYPASS);
      status.forced    = (state_reg == ccd_pkg::ST_FORCE);
   end

endmodule // ccd_top

// *** test/ccd_monitor.sv ***
// concurrent checks on the ports of the clock channel divider
`timescale 1ns/1ps
module ccd_monitor (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_resetn,
   input  wire logic [ccd_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [ccd_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                       i_wr,
   input  wire logic                       i_rd,
   input  wire logic                       i_sync_n,
   input  wire logic [ccd_pkg::DATA_W-1:0] o_rdata,
   input  wire logic                       o_div_out,
   input  wire logic                       o_div_bypass,
   input  wire logic                       o_div_running
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);

   // ----------------------------------------------------------------
   // register shadow and level timing
   // ----------------------------------------------------------------
   ccd_pkg::ccd_period_type  per_reg, per_next;
   ccd_pkg::ccd_control_type ctl_reg, ctl_next;
   logic [5:0]               len_reg, len_next;
   logic                     first_reg, first_next;
   logic                     prev_reg;
   logic                     run_reg;

   always_comb begin
      per_next = per_reg;
      ctl_next = ctl_reg;
      len_next = len_reg + 6'h01;
      first_next = first_reg;
      if (i_wr && i_addr == ccd_pkg::ADDR_PERIOD)
         per_next = ccd_pkg::ccd_period_type'(i_wdata);
      if (i_wr && i_addr == ccd_pkg::ADDR_CONTROL)
         ctl_next = ccd_pkg::ccd_control_type'(i_wdata);
      if (!o_div_running) begin
         len_next = 6'h00;
         first_next = 1'b1;
      end else if (!run_reg || o_div_out != prev_reg) begin
         len_next = 6'h01;
         first_next = !run_reg;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         per_reg <= ccd_pkg::PERIOD_RESET;
         ctl_reg <= ccd_pkg::CONTROL_RESET;
         len_reg <= 6'h00;
         first_reg <= 1'b1;
         prev_reg <= 1'b0;
         run_reg <= 1'b0;
      end else begin
         per_reg <= per_next;
         ctl_reg <= ctl_next;
         len_reg <= len_next;
         first_reg <= first_next;
         prev_reg <= o_div_out;
         run_reg <= o_div_running;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_reset_bypass: assert property (
      $rose(i_resetn) |-> o_div_bypass && !o_div_out)
      else $error("divider not bypassed after reset");
   a_bypass_quiet: assert property (
      (ctl_reg.bypass) [*3] |-> o_div_bypass && !o_div_out && !o_div_running)
      else $error("bypassed divider still active");
   a_run_start: assert property (
      i_wr && i_addr == ccd_pkg::ADDR_CONTROL && i_wdata[7:5] == 3'h0 && i_sync_n
      |-> ##[1:4] o_div_running)
      else $error("divider did not start after bypass cleared");
   a_force_high: assert property (
      (ctl_reg.nosync && ctl_reg.force_high && !ctl_reg.bypass) [*3]
      |-> o_div_out && !o_div_running)
      else $error("forced level not driven");
   a_ignore_sync: assert property (
      o_div_running && $stable(ctl_reg) && ctl_reg[7:5] == 3'h2 |=> o_div_running)
      else $error("divider stopped while sync ignored");
   a_obey_sync: assert property (
      (!i_sync_n && ctl_reg[7:6] == 2'h0) [*6]
      |-> !o_div_running && o_div_out == ctl_reg.start_high)
      else $error("sync did not hold output at start level");
   a_level_len: assert property (
      o_div_running && run_reg && o_div_out != prev_reg
      |-> len_reg == 6'(prev_reg ? per_reg.high_cycles : per_reg.low_cycles)
                     + 6'(first_reg ? ctl_reg.phase : 4'h0) + 6'h01)
      else $error("output level length wrong");
   a_read_ctl: assert property (
      $past(i_rd) && $past(i_addr) == ccd_pkg::ADDR_CONTROL |-> o_rdata == $past(ctl_reg))
      else $error("control read back wrong");
   a_read_period: assert property (
      $past(i_rd) && $past(i_addr) == ccd_pkg::ADDR_PERIOD |-> o_rdata == $past(per_reg))
      else $error("period read back wrong");

   c_level_change: cover property (o_div_running && run_reg && o_div_out != prev_reg);
   c_forced: cover property (o_div_out && !o_div_running && !o_div_bypass);
   c_sync_hold: cover property (!i_sync_n && !o_div_running && !o_div_bypass);
endmodule // ccd_monitor

bind ccd_top ccd_monitor i_ccd_monitor (
   .i_core_clk    (i_core_clk),
   .i_resetn      (i_resetn),
   .i_addr        (i_addr),
   .i_wdata       (i_wdata),
   .i_wr          (i_wr),
   .i_rd          (i_rd),
   .i_sync_n      (i_sync_n),
   .o_rdata       (o_rdata),
   .o_div_out     (o_div_out),
   .o_div_bypass  (o_div_bypass),
   .o_div_running (o_div_running)
);

// *** test/ccd_top_test.sv ***
// self-checking bench of the clock channel divider
`timescale 1ns/1ps
module ccd_top_test;
   logic                       i_core_clk = 1'b0;
   logic                       i_resetn = 1'b0;
   logic [ccd_pkg::ADDR_W-1:0] i_addr = 9'h000;
   logic [ccd_pkg::DATA_W-1:0] i_wdata = 8'h00;
   logic                       i_wr = 1'b0;
   logic                       i_rd = 1'b0;
   logic                       i_sync_n = 1'b1;
   logic [ccd_pkg::DATA_W-1:0] o_rdata;
   logic                       o_div_out;
   logic                       o_div_bypass;
   logic                       o_div_running;
   int                         n_fail = 0;
   int                         num_checks = 0;
   int                         cycles = 0;

   ccd_top i_ccd_top (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_sync_n(i_sync_n), .o_rdata(o_rdata),
      .o_div_out(o_div_out), .o_div_bypass(o_div_bypass), .o_div_running(o_div_running));

   always #2.5 i_core_clk = ~i_core_clk;

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [8:0] a, input logic [7:0] e);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      @(negedge i_core_clk);
      chk("rdata", o_rdata, e);
   endtask

   task automatic pins(input logic b, input logic o, input logic r);
      // a control write reaches the state flop two edges after its strobe
      repeat (3) @(negedge i_core_clk);
      chk("pins", {5'h00, o_div_bypass, o_div_out, o_div_running}, {5'h00, b, o, r});
   endtask

   task automatic sync(input logic v, input int n);
      @(posedge i_core_clk);
      i_sync_n <= v;
      repeat (n) @(posedge i_core_clk);
   endtask

   // lengths of the first three levels after the divider starts
   task automatic runs(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
      logic       lv;
      logic [7:0] n;
      n = 8'h00;
      while (o_div_running !== 1'b1 && n < 8'h32) begin
         @(negedge i_core_clk);
         n++;
      end
      for (int k = 0; k < 3; k++) begin
         lv = o_div_out;
         n = 8'h00;
         while (o_div_out === lv && n < 8'h28) begin
            n++;
            @(negedge i_core_clk);
         end
         chk("level_len", n, (k == 0) ? e0 : (k == 1) ? e1 : e2);
      end
   endtask

   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      rdc(ccd_pkg::ADDR_PERIOD, 8'h00);
      rdc(ccd_pkg::ADDR_CONTROL, 8'h80);
      rdc(9'h0aa, 8'h00);
      pins(1'b1, 1'b0, 1'b0);
      $display("test reset done");
      wr(ccd_pkg::ADDR_PERIOD, 8'h31);
      wr(ccd_pkg::ADDR_CONTROL, 8'h00);
      runs(8'h04, 8'h02, 8'h04);
      $display("test divide done");
      wr(ccd_pkg::ADDR_CONTROL, 8'h80);
      pins(1'b1, 1'b0, 1'b0);
      wr(ccd_pkg::ADDR_PERIOD, 8'h12);
      wr(ccd_pkg::ADDR_CONTROL, 8'h13);
      runs(8'h06, 8'h02, 8'h03);
      rdc(ccd_pkg::ADDR_CONTROL, 8'h13);
      $display("test phase done");
      sync(1'b0, 8);
      pins(1'b0, 1'b1, 1'b0);
      rdc(ccd_pkg::ADDR_STATUS, 8'h25);
      wr(ccd_pkg::ADDR_STATUS, 8'h20);
      rdc(ccd_pkg::ADDR_STATUS, 8'h05);
      sync(1'b1, 0);
      runs(8'h06, 8'h02, 8'h03);
      wr(ccd_pkg::ADDR_CONTROL, 8'h53);
      sync(1'b0, 8);
      @(negedge i_core_clk);
      chk("running", {7'h00, o_div_running}, 8'h01);
      sync(1'b1, 2);
      $display("test sync done");
      wr(ccd_pkg::ADDR_CONTROL, 8'h60);
      repeat (4) @(posedge i_core_clk);
      pins(1'b0, 1'b1, 1'b0);
      wr(ccd_pkg::ADDR_CONTROL, 8'h20);
      repeat (6) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk("running", {7'h00, o_div_running}, 8'h01);
      wr(ccd_pkg::ADDR_CONTROL, 8'h80);
      repeat (3) @(posedge i_core_clk);
      pins(1'b1, 1'b0, 1'b0);
      $display("test force done");
      conclude();
   end
endmodule // ccd_top_test
